/* bench/cep_event_logic_monitor.sv */
/* port checker for the event block.
   assumes a bind from the bench top; sees only the block's ports. */
`default_nettype none
module cep_event_logic_monitor #(
  parameter int unsigned cnt_w = 8
) (
  input wire logic             hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [1:0]       htrans,
  input wire logic [31:0]      haddr, hwdata,
  input wire logic [cnt_w-1:0] irq_mbox_count, mbox_count,
  input wire logic             priv_pend_we, irq_mbox_write_ok, mbox_write_ok, event_pending_any,
  input wire logic [2:0]       priv_pend_data
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic ack_q;
  // marks the data phase of an acknowledge write
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ack_q <= 1'b0;
    else
      ack_q <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == cep_pkg::off_event_ack;
  // counts nonzero for three samples, so no new mailbox space set races a clear; a timer wrap is not excluded
  sequence quiet;
    mbox_count != 0 && irq_mbox_count != 0 && $past(mbox_count) != 0 && $past(irq_mbox_count) != 0
      && $past(mbox_count, 2) != 0 && $past(irq_mbox_count, 2) != 0;
  endsequence
  a_irq_ok_match: assert property (irq_mbox_write_ok == (irq_mbox_count != 0))
    else $error("irq mailbox write ok does not follow its count");
  a_mbox_ok_match: assert property (mbox_write_ok == (mbox_count != 0))
    else $error("mailbox write ok does not follow its count");
  a_irq_mbox_pend: assert property ($past(irq_mbox_count) == 0 && irq_mbox_count != 0 |-> ##[1:2] event_pending_any)
    else $error("irq mailbox space did not set pending");
  a_mbox_pend: assert property ($past(mbox_count) == 0 && mbox_count != 0 |-> ##[1:2] event_pending_any)
    else $error("mailbox space did not set pending");
  a_pend_sticky: assert property ($fell(event_pending_any) |-> $past(ack_q) || $past(ack_q, 2)
    || $past(priv_pend_we) || $past(priv_pend_we, 2)) else $error("pending cleared without a clear");
  a_priv_clear: assert property (priv_pend_we && priv_pend_data == 3'h0 ##0 quiet |=> !event_pending_any)
    else $error("privileged zero write left pending");
  a_ack_all: assert property (ack_q && hwdata[2:0] == 3'h7 ##0 quiet |=> !event_pending_any)
    else $error("full acknowledge left pending");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  c_ack: cover property (ack_q);
  c_priv: cover property (priv_pend_we);
  c_pend: cover property ($rose(event_pending_any));
endmodule // cep_event_logic_monitor
`default_nettype wire

/* bench/cep_event_logic_tb_top.sv */
/* bench top: ahb-lite master queueing expected reads, a watcher, far side model.
   assumes the rtl package and block are compiled first. */
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module cep_event_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, pwe, rd_dp, irq;
  logic        pend_any, iok, mok;
  logic [1:0]  htrans;
  logic [2:0]  pdat, hsz;
  logic [7:0]  icnt, mcnt;
  logic [31:0] haddr, hwdata, hrdata;
  logic [63:0] exp_q[$], cur;
  int          failures = 0, tests_run = 0;
  cep_event_logic #(.cnt_w(8)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsz), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq_mbox_count(icnt), .mbox_count(mcnt), .priv_pend_we(pwe),
    .priv_pend_data(pdat), .irq_mbox_write_ok(iok), .mbox_write_ok(mok), .event_pending_any(pend_any),
    .irq(irq));
  cep_far_model u_far (.hclk(hclk), .irq_mbox_count(icnt), .mbox_count(mcnt));
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // one single transfer; a read leaves its masked expectation on the queue
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, m, e);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsz <= 3'h2;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !w;
    if (!w) exp_q.push_back({m, e});
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_dp <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    xfer(1'b0, a, 32'h0, m, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 32'h0);
  endtask
  // one cycle privileged pending update
  task automatic priv(input logic [2:0] d);
    @(posedge hclk);
    pwe <= 1'b1;
    pdat <= d;
    @(posedge hclk);
    pwe <= 1'b0;
  endtask
  // watcher: read data against the oldest expectation
  always @(posedge hclk)
    if (rd_dp === 1'b1 && hreadyout === 1'b1)
    begin
      cur = exp_q.pop_front();
      `CHK(hrdata & cur[63:32], cur[31:0])
    end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #100000;
    failures++;
    tally_and_finish;
  end
  // main sequence
  initial
  begin
    void'($urandom(77586));
    {hresetn, hsel, hwrite, pwe, rd_dp} = 5'h0;
    {htrans, pdat, hsz, haddr, hwdata} = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    rd(8'h0c, 32'h7, 32'h1);
    rd(8'h40, 32'hffff_ffff, 32'h0);
    wr(8'h00, 32'h7);
    wr(8'h04, 32'h1);
    rd(8'h0c, 32'h7, 32'h0);
    wr(8'h10, 32'h2 + 32'($urandom % 8));
    repeat (20) @(posedge hclk);
    rd(8'h14, 32'h1, 32'h1);
    rd(8'h08, 32'h7, 32'h1);
    rd(8'h14, 32'h1, 32'h0);
    rd(8'h1c, 32'h3, 32'h3);
    rd(8'h10, 32'h8000_0000, 32'h8000_0000);
    wr(8'h20, 32'h3);
    @(negedge hclk) `CHK(irq, 1'b1)
    wr(8'h1c, 32'h3);
    @(negedge hclk) `CHK(irq, 1'b0)
    wr(8'h04, 32'h1);
    rd(8'h00, 32'h7, 32'h7);
    wr(8'h00, 32'h1);
    u_far.drain(1);
    u_far.drain(2);
    repeat (3) @(posedge hclk);
    rd(8'h0c, 32'h7, 32'h6);
    `CHK(pend_any, 1'b1)
    rd(8'h14, 32'h1, 32'h0);
    wr(8'h04, 32'h4);
    rd(8'h0c, 32'h7, 32'h2);
    wr(8'h04, 32'h2);
    rd(8'h0c, 32'h7, 32'h0);
    rd(8'h18, 32'hffff, 32'h0101);
    `CHK({iok, mok}, 2'h3)
    u_far.put(1);
    u_far.put(2);
    wr(8'h00, 32'h7);
    rd(8'h18, 32'hffff, 32'h0);
    `CHK({iok, mok}, 2'h0)
    u_far.drain(1);
    u_far.drain(2);
    repeat (3) @(posedge hclk);
    rd(8'h08, 32'h7, 32'h6);
    priv(3'h4);
    rd(8'h0c, 32'h7, 32'h4);
    wr(8'h04, 32'h7);
    rd(8'h0c, 32'h7, 32'h0);
    `CHK(pend_any, 1'b0)
    wr(8'h10, 32'h2);
    repeat (10) @(posedge hclk);
    @(negedge hclk) `CHK(pend_any, 1'b1)
    priv(3'h0);
    repeat (2) @(posedge hclk);
    rd(8'h0c, 32'h7, 32'h0);
    tally_and_finish;
  end
endmodule // cep_event_logic_tb_top
bind cep_event_logic cep_event_logic_monitor #(.cnt_w(cnt_w)) u_mon (.*);
`default_nettype wire

/* bench/cep_far_model.sv */
/* far side model: outside readers that free mailbox slots and core writes that fill them.
   assumes its tasks are called just after a rising edge of hclk. */
`default_nettype none
module cep_far_model #(
  parameter int unsigned cnt_w = 8
) (
  input  wire logic             hclk,
  output logic      [cnt_w-1:0] irq_mbox_count,
  output logic      [cnt_w-1:0] mbox_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // both mailboxes start full: no free slot
  initial
  begin
    irq_mbox_count = '0;
    mbox_count = '0;
  end
  // an outside reader takes the entry of a full mailbox (1: irq mailbox, 2: mailbox)
  task automatic drain(input int unsigned i);
    if (i == 1) irq_mbox_count <= irq_mbox_count + cnt_w'(1);
    else mbox_count <= mbox_count + cnt_w'(1);
  endtask
  // the core writes one entry only while a slot is free
  task automatic put(input int unsigned i);
    if (i == 1 && irq_mbox_count != 0) irq_mbox_count <= irq_mbox_count - cnt_w'(1);
    if (i == 2 && mbox_count != 0) mbox_count <= mbox_count - cnt_w'(1);
  endtask
endmodule // cep_far_model
`default_nettype wire

/* rtl/cep_edge.sv */
/*
  per-source zero-to-nonzero / rising edge detector for event sources.
  assumes inputs synchronous to hclk.
*/
`default_nettype none
module cep_edge #(
  parameter int unsigned width = 3
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [width-1:0] level_in,
  output logic      [width-1:0] rise_out
);
  logic [width-1:0] prev_q;

  // remember last level
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      prev_q <= '0;
    else
      prev_q <= level_in;
  end

  // one-cycle pulse on 0 to 1
  assign rise_out = level_in & ~prev_q;
endmodule // cep_edge
`default_nettype wire

/* rtl/cep_event_logic.sv */
/*
  channel event pending logic for three sources: decrementer wrap, irq mailbox space, mailbox space.
  each source keeps its own pending bit; masked-in events also raise status bits and the status count.
  software reaches the event registers and the decrementer over an ahb-lite slave with no wait states.
  assumes an ahb-lite single master with word transfers and outbound mailbox counts from outside.
  assumes the mailbox counts and the privileged update strobe are synchronous to hclk.
  assumes nothing else drives hready while this slave is selected.
*/
`default_nettype none
module cep_event_logic #(
  parameter int unsigned cnt_w = 8
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [cnt_w-1:0]  irq_mbox_count,
  input  wire logic [cnt_w-1:0]  mbox_count,
  input  wire logic              priv_pend_we,
  input  wire logic [2:0]        priv_pend_data,
  output logic                   irq_mbox_write_ok,
  output logic                   mbox_write_ok,
  output logic                   event_pending_any,
  output logic                   irq
);
  // register state
  logic [2:0]  mask_q;
  logic [2:0]  pend_q;
  logic [2:0]  stat_q;
  logic        stat_cnt_q;
  logic [31:0] decr_q;
  logic        decr_msb_q;
  logic [1:0]  istat_q;
  logic [1:0]  imask_q;

  // bus pipeline between address and data phase
  logic        addr_ok;
  logic        wr_q;
  logic [7:0]  addr_q;
  logic        rd_q;
  logic [7:0]  rd_addr_q;

  // event sources, pulses and clears
  logic [2:0]  src_lvl;
  logic [2:0]  src_rise;
  logic [2:0]  ev;
  logic [2:0]  ack_bits;
  logic [2:0]  priv_clr;
  logic        wrap;
  logic        stat_set;
  logic [31:0] decr_next;

  // data-phase write strobes and read side effects
  logic        ack_we;
  logic        mask_we;
  logic        decr_we;
  logic        istat_we;
  logic        imask_we;
  logic        stat_rd;

  // interrupt status terms
  logic [1:0]  istat_set;
  logic [1:0]  istat_clr;

  // read words, zero extended to the bus width
  logic [31:0] rd_mask_w;
  logic [31:0] rd_stat_w;
  logic [31:0] rd_pend_w;
  logic [31:0] rd_cnt_w;
  logic [31:0] rd_mbox_w;
  logic [31:0] rd_istat_w;
  logic [31:0] rd_imask_w;
  logic [31:0] rd_mux_d;

  // a transfer is taken when selected, ready and not idle or busy
  // hready low means an earlier transfer still holds the bus
  assign addr_ok = hsel && hready && htrans[1];

  // bus always ready, always okay; hsize is not decoded, every access is a word
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // data-phase direction flags, one cycle after the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else
    begin
      wr_q <= addr_ok && hwrite;
      rd_q <= addr_ok && !hwrite;
    end
  end

  // address held for the data phase; only the low byte is decoded
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_q    <= 8'h00;
      rd_addr_q <= 8'h00;
    end
    else
    begin
      addr_q    <= haddr[7:0];
      rd_addr_q <= haddr[7:0];
    end
  end

  // data-phase write strobes
  assign mask_we  = wr_q && (addr_q == cep_pkg::off_event_mask);
  assign ack_we   = wr_q && (addr_q == cep_pkg::off_event_ack);
  assign decr_we  = wr_q && (addr_q == cep_pkg::off_decrementer);
  assign istat_we = wr_q && (addr_q == cep_pkg::off_irq_status);
  assign imask_we = wr_q && (addr_q == cep_pkg::off_irq_mask);

  // acknowledge bits only count during an acknowledge write
  assign ack_bits = ack_we ? hwdata[2:0] : 3'h0;
  // privileged update clears every bit written as zero
  assign priv_clr = priv_pend_we ? ~priv_pend_data : 3'h0;
  // reading event status consumes the status count
  assign stat_rd  = rd_q && (rd_addr_q == cep_pkg::off_event_status);

  // next count: runs through zero into negative values
  // after a wrap the count keeps going so software can read how late it is
  assign decr_next = decr_q - 32'h1;

  // decrementer: loads on write, otherwise counts down
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      decr_q <= cep_pkg::decr_reset;
    else if (decr_we)
      decr_q <= hwdata;
    else
      decr_q <= decr_next;
  end

  // previous msb of the count
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      decr_msb_q <= 1'b0;
    else
      decr_msb_q <= decr_q[31];
  end

  // zero to negative crossing of the count; a reload to a positive value never fires
  assign wrap = decr_q[31] && !decr_msb_q;

  // space levels: nonzero count means a write will not stall
  assign irq_mbox_write_ok = (irq_mbox_count != '0);
  assign mbox_write_ok     = (mbox_count != '0);
  // bit 0 is the timer slot and has no level source
  assign src_lvl = {mbox_write_ok, irq_mbox_write_ok, 1'b0};

  // zero-to-nonzero detection for the mailbox sources
  // previous levels reset to zero, the full state, so reset release makes no false edge
  cep_edge #(
    .width (3)
  ) u_edge (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .level_in (src_lvl),
    .rise_out (src_rise)
  );

  // per-source event pulses
  assign ev[cep_pkg::timer_event_bit]       = wrap;
  assign ev[cep_pkg::irq_mailbox_space_bit] = src_rise[cep_pkg::irq_mailbox_space_bit];
  assign ev[cep_pkg::mailbox_space_bit]     = src_rise[cep_pkg::mailbox_space_bit];

  // event mask
  // mask bits gate status bits and status count, never the pending bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mask_q <= cep_pkg::mask_reset;
    else if (mask_we)
      mask_q <= hwdata[2:0];
  end

  // independent pending and status bits per source, set wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_ev
      // pending: set by the source, cleared by acknowledge or privileged write
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          pend_q[gi] <= 1'b0;
        else if (ev[gi])
          pend_q[gi] <= 1'b1;
        else if (ack_bits[gi])
          pend_q[gi] <= 1'b0;
        else if (priv_clr[gi])
          pend_q[gi] <= 1'b0;
      end

      // status: set only for an event whose mask bit is one
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          stat_q[gi] <= 1'b0;
        else if (ev[gi] && mask_q[gi])
          stat_q[gi] <= 1'b1;
        else if (ack_bits[gi] || priv_clr[gi])
          stat_q[gi] <= 1'b0;
      end
    end
  endgenerate

  // status count is raised by any masked-in event
  assign stat_set = |(ev & mask_q);

  // event status channel count
  // set wins over the clearing read in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stat_cnt_q <= 1'b0;
    else if (stat_set)
      stat_cnt_q <= 1'b1;
    else if (stat_rd)
      stat_cnt_q <= 1'b0;
  end

  // interrupt status terms: status count level and wrap pulse set, write one clears
  assign istat_set = {wrap, stat_cnt_q};
  assign istat_clr = istat_we ? hwdata[1:0] : 2'h0;

  // interrupt status: sticky, set wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      istat_q <= 2'h0;
    else
      istat_q <= istat_set | (istat_q & ~istat_clr);
  end

  // interrupt mask
  // only enabled interrupt status bits reach the irq pin
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      imask_q <= 2'h0;
    else if (imask_we)
      imask_q <= hwdata[1:0];
  end

  // level interrupt while an unmasked status bit is set
  assign irq               = |(istat_q & imask_q);
  // any source still pending
  assign event_pending_any = |pend_q;

  // read words, unused upper bits read zero
  assign rd_mask_w  = {29'h0, mask_q};
  assign rd_stat_w  = {29'h0, stat_q};
  assign rd_pend_w  = {29'h0, pend_q};
  assign rd_cnt_w   = {31'h0, stat_cnt_q};
  assign rd_mbox_w  = {16'h0, 8'(irq_mbox_count), 8'(mbox_count)};
  assign rd_istat_w = {30'h0, istat_q};
  assign rd_imask_w = {30'h0, imask_q};

  // read select on the address phase offset
  always_comb
  begin
    rd_mux_d = 32'h0000_0000;
    case (haddr[7:0])
      cep_pkg::off_event_mask:   rd_mux_d = rd_mask_w;
      cep_pkg::off_event_status: rd_mux_d = rd_stat_w;
      cep_pkg::off_pending:      rd_mux_d = rd_pend_w;
      cep_pkg::off_decrementer:  rd_mux_d = decr_q;
      cep_pkg::off_status_count: rd_mux_d = rd_cnt_w;
      cep_pkg::off_mbox_count:   rd_mux_d = rd_mbox_w;
      cep_pkg::off_irq_status:   rd_mux_d = rd_istat_w;
      cep_pkg::off_irq_mask:     rd_mux_d = rd_imask_w;
      default:                   rd_mux_d = 32'h0000_0000;
    endcase
  end

  // read data registered at the address phase, so it stands through the data phase
  // hrdata keeps its value until the next read is taken
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_ok && !hwrite)
      hrdata <= rd_mux_d;
  end
endmodule // cep_event_logic
`default_nettype wire

/* rtl/cep_pkg.sv */
/*
  constants for the channel event pending logic: register offsets, event bit positions, reset values.
  assumes a single 100 MHz clock and an ahb-lite register bus with 32-bit word registers.
*/
// Contract
// - set timer pending bit when decrementer msb goes from 0 to 1.
// - timer event with mask set raises status count to 1 and timer status bit.
// - privileged pending-register write clears any pending bit written as zero.
// - set irq mailbox space pending when its count goes from zero to nonzero.
// - irq mailbox space event with mask set raises status count and status bit.
// - set mailbox space pending when outbound mailbox count goes from zero to nonzero.
// - mailbox space event with mask set raises status count and status bit.
// - acknowledge write with mailbox space bit one clears that pending bit.
// - nonzero outbound mailbox count means a write completes without stalling.
// - decrementer keeps counting below zero; reads return negative overrun.
// - writing the decrementer channel loads a fresh count for another timer event.
`default_nettype none
package cep_pkg;
  localparam int unsigned n_events = 3;
  // event bit positions
  localparam int unsigned timer_event_bit         = 0;
  localparam int unsigned irq_mailbox_space_bit   = 1;
  localparam int unsigned mailbox_space_bit       = 2;
  // register byte offsets
  localparam logic [7:0] off_event_mask           = 8'h00;
  localparam logic [7:0] off_event_ack            = 8'h04;
  localparam logic [7:0] off_event_status         = 8'h08;
  localparam logic [7:0] off_pending              = 8'h0c;
  localparam logic [7:0] off_decrementer          = 8'h10;
  localparam logic [7:0] off_status_count         = 8'h14;
  localparam logic [7:0] off_mbox_count           = 8'h18;
  localparam logic [7:0] off_irq_status           = 8'h1c;
  localparam logic [7:0] off_irq_mask             = 8'h20;
  // reset values
  localparam logic [2:0]  mask_reset              = 3'h0;
  localparam logic [31:0] decr_reset              = 32'h0000_0000;
  // interrupt status bits
  localparam int unsigned n_irq                   = 2;
  localparam int unsigned irq_status_bit          = 0;
  localparam int unsigned irq_timer_wrap_bit      = 1;
endpackage
`default_nettype wire
